//--- verilog/csc_consts.vh
// Constants for the system clock source control block
`ifndef CSC_CONSTS_VH
`define CSC_CONSTS_VH

// Register addresses on the special function register port
`define CSC_ADDR_EXT_OSC_CTRL   8'hB1
`define CSC_ADDR_INT_OSC_CTRL   8'hB2

// Reset values
`define CSC_RST_EXT_OSC_CTRL    8'h30
`define CSC_RST_INT_OSC_CTRL    8'h04

// internal_osc_control field positions
`define CSC_MCD_EN_BIT          7
`define CSC_FREQ_READY_BIT      4
`define CSC_CLK_SEL_BIT         3
`define CSC_INT_EN_BIT          2
`define CSC_INT_FREQ_HI         1
`define CSC_INT_FREQ_LO         0

// external_osc_control field positions
`define CSC_XTAL_VALID_BIT      7
`define CSC_EXT_MODE_HI         6
`define CSC_EXT_MODE_LO         4
`define CSC_EXT_RANGE_HI        2
`define CSC_EXT_RANGE_LO        0

// External mode codes
`define CSC_MODE_CMOS           3'h2
`define CSC_MODE_CMOS_DIV2      3'h3
`define CSC_MODE_XTAL_DIV2      3'h7

// Timing in 25 MHz core cycles: 1 ms crystal wait, 100 us clock timeout
`define CSC_XTAL_WAIT_CYC       16'h61A8
`define CSC_MCD_TIMEOUT_CYC     16'h09C4

// Dead time between clock gates while switching, and frequency settle time
`define CSC_SWITCH_GAP_CYC      4'h2
`define CSC_FREQ_SETTLE_CYC     8'h10

`endif

//--- verilog/csc_top.v
// System clock source control: oscillator registers, clock mux, clock watch
//
// Behaviour
// - Every reset brings the system clock back onto the internal oscillator.
// - While the reset pin is low both oscillators stay disabled.
// - Bit 7 enables missing clock detection; a missing clock resets.
// - Internal control bits 6 and 5 read zero and ignore writes.
// - Bit 4 shows internal oscillator running at selected frequency.
// - Bit 3 picks internal (0) or external (1) system clock.
// - Bit 2 switches the internal oscillator on or off while the external clock runs.
// - Bits 1-0 choose 2, 4, 8 or 16 MHz internal frequency.
// - Crystal valid flag is read only, meaningful in modes 11x.
// - Modes 00x switch the external oscillator off and ground the pin.
// - Mode 010 takes CMOS clock directly, 011 divided by two.
// - Modes 10x RC/C with divide by two; 110 crystal; 111 halved.
// - External control bit 3 is reserved and ignores writes.
// - Bits 2-0 pick one of eight external drive ranges.
// - Crystal valid rises once stable, never before 1 ms after enable.
// - Missing clock reset flag reads 1 only after such a reset.

`include "csc_consts.vh"

module csc_top #(
  parameter [15:0] XTAL_WAIT_CYC   = `CSC_XTAL_WAIT_CYC,
  parameter [15:0] MCD_TIMEOUT_CYC = `CSC_MCD_TIMEOUT_CYC,
  parameter [3:0]  SWITCH_GAP_CYC  = `CSC_SWITCH_GAP_CYC,
  parameter [7:0]  FREQ_SETTLE_CYC = `CSC_FREQ_SETTLE_CYC
) (
  input  wire       CORE_CLK_I,
  input  wire       RESET_N_I,
  input  wire       OTHER_RESET_I,
  input  wire [7:0] SFR_ADDR_I,
  input  wire       SFR_WE_I,
  input  wire       SFR_RE_I,
  input  wire [7:0] SFR_WDATA_I,
  input  wire       INT_OSC_STABLE_I,
  input  wire       XTAL_STABLE_I,
  input  wire       SYS_CLK_TICK_I,
  output reg  [7:0] SFR_RDATA_O,
  output reg        INT_OSC_EN_O,
  output reg  [1:0] INT_FREQ_SEL_O,
  output reg        EXT_OSC_EN_O,
  output reg  [2:0] EXT_MODE_O,
  output reg  [2:0] EXT_DRIVE_RANGE_O,
  output reg        EXT_DIV2_O,
  output reg        CRYSTAL_PIN_GND_O,
  output reg        SYS_CLK_INT_GATE_O,
  output reg        SYS_CLK_EXT_GATE_O,
  output reg        MCD_RESET_O,
  output reg        MISSING_CLOCK_RESET_FLAG_O
);

  //////////////////////////////////////////////////////////////////////////
  // Overview: two control registers sit on the register strobes. The
  // internal one holds the detector enable, the source select, the
  // internal oscillator enable and its frequency code; the external one
  // holds the oscillator mode and the drive range. Status flags (ready,
  // crystal valid) are made here from the analog stability inputs and
  // are never stored from a write.
  //
  // The clock itself never passes through this block: it only drives the
  // two gate enables of the system clock multiplexer, so every output is
  // a flip-flop and no combinational path reaches the analog side.
  // Timing counts are parameters so a bench can shorten them.
  //
  //////////////////////////////////////////////////////////////////////////
  // Clock mux states, one-hot
  localparam [3:0] ST_INT    = 4'h1;
  localparam [3:0] ST_TO_EXT = 4'h2;
  localparam [3:0] ST_EXT    = 4'h4;
  localparam [3:0] ST_TO_INT = 4'h8;

  // External oscillator runs in every mode but 00x; in 00x the first
  // crystal pin is grounded so a floating pin cannot clock anything
  function ext_on;
    input [2:0] mode;
    begin
      ext_on = (mode[2:1] != 2'b00);
    end
  endfunction

  // Divide-by-two stage in 011, 10x and 111; the plain CMOS and plain
  // crystal modes pass the source straight through
  function ext_div2;
    input [2:0] mode;
    begin
      ext_div2 = (mode == `CSC_MODE_CMOS_DIV2) || (mode[2:1] == 2'b10) ||
                 (mode == `CSC_MODE_XTAL_DIV2);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Register state
  // Stored fields of the two control registers
  reg        mcd_en_ff;
  reg        clk_sel_ff;
  reg        int_en_ff;
  reg  [1:0] int_freq_ff;
  reg  [2:0] ext_mode_ff;
  reg  [2:0] ext_range_ff;

  // Status counters and flags
  reg  [7:0] settle_cnt_ff;
  reg        freq_ready_ff;
  reg [15:0] xtal_cnt_ff;
  reg        xtal_valid_ff;
  reg [15:0] mcd_cnt_ff;

  // Multiplexer sequencer
  reg  [3:0] state_ff;
  reg  [3:0] gap_cnt_ff;
  reg  [3:0] nxt_state;
  reg  [3:0] nxt_gap_cnt;

  // Write decode; a missing clock timeout acts as a soft reset here, as
  // the chip-level reset it requests may arrive a few cycles later
  wire wr_int    = SFR_WE_I && (SFR_ADDR_I == `CSC_ADDR_INT_OSC_CTRL);
  wire wr_ext    = SFR_WE_I && (SFR_ADDR_I == `CSC_ADDR_EXT_OSC_CTRL);
  wire xtal_mode = (ext_mode_ff[2:1] == 2'b11);
  wire mcd_fire  = mcd_en_ff && (mcd_cnt_ff >= MCD_TIMEOUT_CYC);
  wire soft_rst  = mcd_fire || OTHER_RESET_I;

  // Reset images and incoming write fields
  wire [7:0] rst_int = `CSC_RST_INT_OSC_CTRL;
  wire [7:0] rst_ext = `CSC_RST_EXT_OSC_CTRL;
  wire [2:0] nxt_mode = SFR_WDATA_I[`CSC_EXT_MODE_HI:`CSC_EXT_MODE_LO];
  wire [1:0] nxt_freq = SFR_WDATA_I[`CSC_INT_FREQ_HI:`CSC_INT_FREQ_LO];

  // Switch request; any soft reset withdraws it at once
  wire want_ext  = clk_sel_ff && ext_on(ext_mode_ff) && !soft_rst;
  wire gap_done  = (gap_cnt_ff >= SWITCH_GAP_CYC);

  //////////////////////////////////////////////////////////////////////////
  // Control registers; a soft reset restores defaults as any reset does
  // A soft reset in the same cycle as a write wins, so software cannot
  // leave a half-applied setting behind the reset
  always @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      mcd_en_ff    <= 1'b0;
      clk_sel_ff   <= 1'b0;
      int_en_ff    <= 1'b1;
      int_freq_ff  <= 2'h0;
      ext_mode_ff  <= 3'h3;
      ext_range_ff <= 3'h0;
    end else if (soft_rst) begin
      mcd_en_ff    <= rst_int[`CSC_MCD_EN_BIT];
      clk_sel_ff   <= rst_int[`CSC_CLK_SEL_BIT];
      int_en_ff    <= rst_int[`CSC_INT_EN_BIT];
      int_freq_ff  <= rst_int[`CSC_INT_FREQ_HI:`CSC_INT_FREQ_LO];
      ext_mode_ff  <= rst_ext[`CSC_EXT_MODE_HI:`CSC_EXT_MODE_LO];
      ext_range_ff <= rst_ext[`CSC_EXT_RANGE_HI:`CSC_EXT_RANGE_LO];
    end else begin
      if (wr_int) begin
        // Bits 6-5 and the ready flag are not stored
        mcd_en_ff   <= SFR_WDATA_I[`CSC_MCD_EN_BIT];
        clk_sel_ff  <= SFR_WDATA_I[`CSC_CLK_SEL_BIT];
        int_en_ff   <= SFR_WDATA_I[`CSC_INT_EN_BIT];
        int_freq_ff <= nxt_freq;
      end
      if (wr_ext) begin
        // Valid flag and reserved bit 3 are not stored
        ext_mode_ff  <= nxt_mode;
        ext_range_ff <= SFR_WDATA_I[`CSC_EXT_RANGE_HI:`CSC_EXT_RANGE_LO];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Internal frequency ready: settle after enable or frequency change
  // The flag drops in the cycle after a frequency change, before the
  // oscillator has moved, so software never reads a stale ready
  always @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      settle_cnt_ff <= 8'h00;
      freq_ready_ff <= 1'b0;
    end else if (soft_rst || !int_en_ff || !INT_OSC_STABLE_I ||
                 (wr_int && (nxt_freq != int_freq_ff))) begin
      settle_cnt_ff <= 8'h00;
      freq_ready_ff <= 1'b0;
    end else if (settle_cnt_ff >= FREQ_SETTLE_CYC) begin
      freq_ready_ff <= 1'b1;
    end else begin
      settle_cnt_ff <= settle_cnt_ff + 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Crystal valid: startup wait, then follows the stability detector
  // The wait restarts on every mode change away from crystal, so a
  // detector that was stable in an earlier mode cannot vouch for this one
  always @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      xtal_cnt_ff   <= 16'h0000;
      xtal_valid_ff <= 1'b0;
    end else if (soft_rst || !xtal_mode ||
                 (wr_ext && (nxt_mode[2:1] != 2'b11))) begin
      xtal_cnt_ff   <= 16'h0000;
      xtal_valid_ff <= 1'b0;
    end else if (xtal_cnt_ff >= XTAL_WAIT_CYC) begin
      xtal_valid_ff <= XTAL_STABLE_I;
    end else begin
      xtal_cnt_ff   <= xtal_cnt_ff + 16'h0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Missing clock detector: counts core cycles since the last clock tick
  // Limitation: a tick shorter than a core cycle is not seen; the
  // oscillator side must stretch it to one core clock
  always @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      mcd_cnt_ff <= 16'h0000;
    end else if (!mcd_en_ff || SYS_CLK_TICK_I || mcd_fire) begin
      mcd_cnt_ff <= 16'h0000;
    end else begin
      mcd_cnt_ff <= mcd_cnt_ff + 16'h0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Reset source flag: only a detector timeout sets it
  // The flag is written on every soft reset, so a later reset from any
  // other source clears it; the pin reset clears it as well
  always @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      MISSING_CLOCK_RESET_FLAG_O <= 1'b0;
      MCD_RESET_O                <= 1'b0;
    end else begin
      MCD_RESET_O <= mcd_fire;
      if (soft_rst) begin
        MISSING_CLOCK_RESET_FLAG_O <= mcd_fire;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Clock mux sequencer: both gates closed for a gap between sources
  // Closing one gate, waiting, then opening the other means the system
  // clock sees a pause but never a clipped high or low phase
  always @* begin
    nxt_state   = state_ff;
    nxt_gap_cnt = 4'h0;
    case (state_ff)
      // Running on the internal oscillator
      ST_INT: begin
        if (want_ext) begin
          nxt_state = ST_TO_EXT;
        end
      end
      // Both gates shut on the way to the external source
      ST_TO_EXT: begin
        if (!want_ext) begin
          nxt_state = ST_TO_INT;
        end else if (gap_done) begin
          nxt_state = ST_EXT;
        end else begin
          nxt_gap_cnt = gap_cnt_ff + 4'h1;
        end
      end
      // Running on the external source
      ST_EXT: begin
        if (!want_ext) begin
          nxt_state = ST_TO_INT;
        end
      end
      // Both gates shut on the way back to the internal oscillator
      ST_TO_INT: begin
        if (soft_rst || gap_done) begin
          nxt_state = ST_INT;
        end else begin
          nxt_gap_cnt = gap_cnt_ff + 4'h1;
        end
      end
      default: begin
        nxt_state = ST_INT;
      end
    endcase
  end

  // Sequencer state and gate outputs
  // Gates follow the next state, so they change on the same edge as it
  always @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state_ff           <= ST_INT;
      gap_cnt_ff         <= 4'h0;
      SYS_CLK_INT_GATE_O <= 1'b0;
      SYS_CLK_EXT_GATE_O <= 1'b0;
    end else begin
      state_ff           <= nxt_state;
      gap_cnt_ff         <= nxt_gap_cnt;
      SYS_CLK_INT_GATE_O <= (nxt_state == ST_INT);
      SYS_CLK_EXT_GATE_O <= (nxt_state == ST_EXT);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Oscillator drive outputs; both oscillators off and crystal pin grounded while the reset pin is low
  // Outputs copy the stored fields one cycle later; the analog side sees
  // a clean registered level and never a decode glitch
  always @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      INT_OSC_EN_O      <= 1'b0;
      INT_FREQ_SEL_O    <= 2'h0;
      EXT_OSC_EN_O      <= 1'b0;
      EXT_MODE_O        <= 3'h0;
      EXT_DRIVE_RANGE_O <= 3'h0;
      EXT_DIV2_O        <= 1'b0;
      CRYSTAL_PIN_GND_O <= 1'b1;
    end else begin
      // Internal oscillator forced on while it is the clock source
      INT_OSC_EN_O      <= int_en_ff || (nxt_state != ST_EXT);
      INT_FREQ_SEL_O    <= int_freq_ff;
      EXT_OSC_EN_O      <= ext_on(ext_mode_ff);
      EXT_MODE_O        <= ext_mode_ff;
      EXT_DRIVE_RANGE_O <= ext_range_ff;
      EXT_DIV2_O        <= ext_div2(ext_mode_ff);
      CRYSTAL_PIN_GND_O <= !ext_on(ext_mode_ff);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register read port: data one cycle after the read strobe
  // Idle read data is zero, so a stray strobe cannot pick up a stale
  // value; reserved and unused bits always read zero
  always @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      SFR_RDATA_O <= 8'h00;
    end else if (SFR_RE_I &&
                 (SFR_ADDR_I == `CSC_ADDR_INT_OSC_CTRL)) begin
      SFR_RDATA_O <= {mcd_en_ff, 2'b00, freq_ready_ff,
                      clk_sel_ff, int_en_ff, int_freq_ff};
    end else if (SFR_RE_I &&
                 (SFR_ADDR_I == `CSC_ADDR_EXT_OSC_CTRL)) begin
      SFR_RDATA_O <= {xtal_valid_ff, ext_mode_ff, 1'b0,
                      ext_range_ff};
    end else begin
      SFR_RDATA_O <= 8'h00;
    end
  end

endmodule

//--- sim/csc_osc_model.sv
// Oscillator start-up and clock activity model for the clock block
module csc_osc_model #(
  parameter int INT_DLY  = 3,
  parameter int XTAL_DLY = 30
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       int_en_i,
  input  wire logic       ext_en_i,
  input  wire logic [2:0] mode_i,
  input  wire logic       int_gate_i,
  input  wire logic       ext_gate_i,
  input  wire logic       stall_i,
  output logic            int_stable_o,
  output logic            xtal_stable_o,
  output logic            tick_o
);
  int int_cnt;
  int xtal_cnt;
  logic xmode;
  ////////////////////////////////////////////////////////////////////////////
  // Start-up counters; a crystal only builds up while driven in mode 11x
  assign xmode = ext_en_i && (mode_i[2:1] == 2'b11);
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      int_cnt <= 0;
      xtal_cnt <= 0;
    end else begin
      int_cnt <= int_en_i ? int_cnt + (int_cnt < INT_DLY) : 0;
      xtal_cnt <= xmode ? xtal_cnt + (xtal_cnt < XTAL_DLY) : 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Levels and activity; a stalled or unsettled source gives no ticks
  assign int_stable_o = int_en_i && (int_cnt >= INT_DLY);
  assign xtal_stable_o = xmode && (xtal_cnt >= XTAL_DLY);
  assign tick_o = !stall_i && ((int_gate_i && int_stable_o) ||
                  (ext_gate_i && ext_en_i && (!xmode || xtal_stable_o)));
endmodule

//--- sim/csc_top_sva.sv
// Port checks for the system clock source control block
module csc_top_sva #(
  parameter [3:0] SWITCH_GAP_CYC = 4'h2
) (
  input wire       CORE_CLK_I,
  input wire       RESET_N_I,
  input wire       OTHER_RESET_I,
  input wire [7:0] SFR_ADDR_I,
  input wire       SFR_WE_I,
  input wire       SFR_RE_I,
  input wire [7:0] SFR_WDATA_I,
  input wire [7:0] SFR_RDATA_O,
  input wire       INT_OSC_EN_O,
  input wire [1:0] INT_FREQ_SEL_O,
  input wire       EXT_OSC_EN_O,
  input wire [2:0] EXT_MODE_O,
  input wire       EXT_DIV2_O,
  input wire       CRYSTAL_PIN_GND_O,
  input wire       SYS_CLK_INT_GATE_O,
  input wire       SYS_CLK_EXT_GATE_O,
  input wire       MCD_RESET_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  reg  [3:0] low_cnt_ff;
  wire       both_low = !SYS_CLK_INT_GATE_O && !SYS_CLK_EXT_GATE_O;
  wire [3:0] nxt_low_cnt = !both_low ? 4'h0 :
                           low_cnt_ff + {3'h0, low_cnt_ff != 4'hF};
  wire [1:0] wr_freq = SFR_WDATA_I[1:0];
  wire       mode_off = (EXT_MODE_O[2:1] == 2'b00);
  wire       div2 = (EXT_MODE_O == 3'h3) || (EXT_MODE_O[2:1] == 2'b10) ||
                    (EXT_MODE_O == 3'h7);
  ////////////////////////////////////////////////////////////////////////////
  // Cycles with both clock gates shut
  always @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I)
      low_cnt_ff <= 4'h0;
    else
      low_cnt_ff <= nxt_low_cnt;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_gates_exclusive: assert property (
    !(SYS_CLK_INT_GATE_O && SYS_CLK_EXT_GATE_O)) else $error("both gates");
  a_pin_osc_off: assert property (disable iff (1'b0)
    !RESET_N_I |-> !INT_OSC_EN_O && !EXT_OSC_EN_O) else $error("osc on");
  a_boot_internal: assert property ($rose(RESET_N_I) |=>
    SYS_CLK_INT_GATE_O && INT_OSC_EN_O) else $error("no internal boot");
  a_mode_off_gnd: assert property (mode_off |->
    CRYSTAL_PIN_GND_O && !EXT_OSC_EN_O) else $error("pin not grounded");
  a_div2_modes: assert property (
    EXT_DIV2_O == div2) else $error("divider wrong");
  a_switch_gap: assert property ($rose(SYS_CLK_EXT_GATE_O) |->
    low_cnt_ff >= SWITCH_GAP_CYC + 4'h1) else $error("gap short");
  a_ext_needs_mode: assert property ($rose(SYS_CLK_EXT_GATE_O) |->
    !mode_off) else $error("ext gate with mode off");
  a_freq_follow: assert property (SFR_WE_I && SFR_ADDR_I == 8'hB2 &&
    !OTHER_RESET_I ##1 !MCD_RESET_O |=> INT_FREQ_SEL_O == $past(wr_freq, 2))
    else $error("freq not taken");
  a_mcd_one_pulse: assert property (MCD_RESET_O |=>
    !MCD_RESET_O && !SYS_CLK_EXT_GATE_O) else $error("mcd pulse");
  a_unused_zero: assert property ($past(SFR_RE_I) &&
    $past(SFR_ADDR_I) == 8'hB2 |-> SFR_RDATA_O[6:5] == 2'b00)
    else $error("unused bits set");
  c_ext_on: cover property ($rose(SYS_CLK_EXT_GATE_O));
  c_ext_off: cover property ($fell(SYS_CLK_EXT_GATE_O));
  c_mcd: cover property (MCD_RESET_O);
endmodule

bind csc_top csc_top_sva #(.SWITCH_GAP_CYC(SWITCH_GAP_CYC)) i_sva (
  .CORE_CLK_I(CORE_CLK_I), .RESET_N_I(RESET_N_I), .SFR_ADDR_I(SFR_ADDR_I),
  .OTHER_RESET_I(OTHER_RESET_I),
  .SFR_WE_I(SFR_WE_I), .SFR_RE_I(SFR_RE_I), .SFR_WDATA_I(SFR_WDATA_I),
  .SFR_RDATA_O(SFR_RDATA_O), .INT_OSC_EN_O(INT_OSC_EN_O),
  .INT_FREQ_SEL_O(INT_FREQ_SEL_O), .EXT_OSC_EN_O(EXT_OSC_EN_O),
  .EXT_MODE_O(EXT_MODE_O), .EXT_DIV2_O(EXT_DIV2_O),
  .CRYSTAL_PIN_GND_O(CRYSTAL_PIN_GND_O), .MCD_RESET_O(MCD_RESET_O),
  .SYS_CLK_INT_GATE_O(SYS_CLK_INT_GATE_O),
  .SYS_CLK_EXT_GATE_O(SYS_CLK_EXT_GATE_O));

//--- sim/csc_top_bench.sv
// Self-checking bench for the system clock source control block
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  error_cnt++; $display("mismatch %s exp %h got %h", n, e, g); end end
`define WT(c, l) begin n = 0; while (!(c) && n < l) begin \
  @(posedge clk); #1; n++; end if (!(c)) begin error_cnt++; \
  $display("mismatch wait exp 1 got 0"); results(); end end
module csc_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk = 1'b0, rst_n = 1'b1, oth = 1'b0, we = 1'b0, re = 1'b0;
  logic       stall = 1'b0, seen, int_st, x_st, tick, int_en, ext_en;
  logic       div2, gnd, i_gt, x_gt, mcd, flag;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, a, d, e, v;
  logic [2:0] mode, rng;
  logic [1:0] freq;
  int         error_cnt = 0, total_checks = 0, n;
  logic [23:0] rows [0:13] = '{24'hB2_6414, 24'hB2_1515, 24'hB2_0616,
    24'hB2_2717, 24'hB1_0800, 24'hB1_1F17, 24'hB1_A921, 24'hB1_3A32,
    24'hB1_4B43, 24'hB1_5C54, 24'hB1_2D25, 24'hB1_7E76, 24'h55_FF00,
    24'hB1_3030};
  always #20 clk = ~clk;
  csc_top #(.XTAL_WAIT_CYC(16'h0014), .MCD_TIMEOUT_CYC(16'h0010),
    .FREQ_SETTLE_CYC(8'h02)) i_dut (.CORE_CLK_I(clk), .RESET_N_I(rst_n),
    .OTHER_RESET_I(oth), .SFR_ADDR_I(addr), .SFR_WE_I(we), .SFR_RE_I(re),
    .SFR_WDATA_I(wdata), .INT_OSC_STABLE_I(int_st), .XTAL_STABLE_I(x_st),
    .SYS_CLK_TICK_I(tick), .SFR_RDATA_O(rdata), .INT_OSC_EN_O(int_en),
    .INT_FREQ_SEL_O(freq), .EXT_OSC_EN_O(ext_en), .EXT_MODE_O(mode),
    .EXT_DRIVE_RANGE_O(rng), .EXT_DIV2_O(div2), .CRYSTAL_PIN_GND_O(gnd),
    .SYS_CLK_INT_GATE_O(i_gt), .SYS_CLK_EXT_GATE_O(x_gt),
    .MCD_RESET_O(mcd), .MISSING_CLOCK_RESET_FLAG_O(flag));
  csc_osc_model i_osc (.clk_i(clk), .rst_n_i(rst_n), .int_en_i(int_en),
    .ext_en_i(ext_en), .mode_i(mode), .int_gate_i(i_gt), .ext_gate_i(x_gt),
    .stall_i(stall), .int_stable_o(int_st), .xtal_stable_o(x_st),
    .tick_o(tick));
  ////////////////////////////////////////////////////////////////////////////
  // Register strobes, one byte per access
  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    @(posedge clk);
    #1 {addr, wdata, we} = {ad, dt, 1'b1};
    @(posedge clk);
    #1 we = 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [7:0] dt);
    @(posedge clk);
    #1 {addr, re} = {ad, 1'b1};
    @(posedge clk);
    #1 re = 1'b0;
    dt = rdata;
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Reset, register table, then crystal, detector and pin reset cases
  initial begin
    #1 rst_n = 1'b0;
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    rd(8'hB1, v);
    `CHK("ext reset", 8'h30, v)
    repeat (8) @(posedge clk);
    rd(8'hB2, v);
    `CHK("int reset", 8'h14, v)
    foreach (rows[i]) begin
      {a, d, e} = rows[i];
      wr(a, d);
      repeat (6) @(posedge clk);
      rd(a, v);
      `CHK("read", e, v)
      if (a == 8'hB2) `CHK("freq", e[1:0], freq)
      if (a == 8'hB1) begin
        `CHK("mode", {e[6:4], e[2:0]}, {mode, rng})
        `CHK("div2", e[6:4] inside {3'h3, 3'h4, 3'h5, 3'h7}, div2)
        `CHK("gnd", e[6:5] == 2'b00, gnd)
      end
    end
    wr(8'hB1, 8'h67);
    n = 0;
    v = 8'h00;
    while (!v[7] && n < 60) begin
      rd(8'hB1, v);
      n++;
    end
    `CHK("valid", 8'hE7, v)
    `CHK("early", 1'b1, n > 9)
    wr(8'hB2, 8'h0C);
    `WT(x_gt, 12)
    `CHK("int gate", 1'b0, i_gt)
    wr(8'hB2, 8'h08);
    repeat (3) @(posedge clk);
    `CHK("int osc", 1'b0, int_en)
    rd(8'hB2, v);
    `CHK("ready off", 1'b0, v[4])
    wr(8'hB1, 8'h00);
    `WT(i_gt, 12)
    `CHK("ext off", 2'b01, {ext_en, gnd})
    wr(8'hB1, 8'h20);
    wr(8'hB2, 8'h8C);
    `WT(x_gt, 12)
    stall = 1'b1;
    `WT(mcd, 40)
    stall = 1'b0;
    repeat (2) @(posedge clk);
    `CHK("mcd flag", 1'b1, flag)
    rd(8'hB2, v);
    `CHK("after mcd", 2'b00, {v[7], v[3]})
    stall = 1'b1;
    seen = 1'b0;
    repeat (40) begin
      @(posedge clk);
      #1 seen = seen | mcd;
    end
    stall = 1'b0;
    `CHK("mcd off", 1'b0, seen)
    oth = 1'b1;
    @(posedge clk);
    #1 oth = 1'b0;
    `CHK("flag clear", 1'b0, flag)
    wr(8'hB1, 8'h20);
    wr(8'hB2, 8'h0C);
    `WT(x_gt, 12)
    rst_n = 1'b0;
    @(posedge clk);
    #1 `CHK("pin rst", 2'b00, {int_en, ext_en})
    rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1 `CHK("boot", 2'b10, {i_gt, x_gt})
    results();
  end
endmodule
